// >>> ccout_pkg.sv
// Purpose: Constants for the compare output timer block.
// Assumes: APB slave, 32-bit data, one aligned word per register.
// Notes: Offsets are byte addresses.
//
// How it works
// - Mode field zero leaves the waveform output unchanged at a match.
// - Normal mode: compare output follows waveform output one cycle later.
// - PWM with mode 01 makes a true/inverted pair with dead time.
// - PWM with other nonzero modes behaves like Normal output path.
// - Reset forces the compare output state to zero.
// - Nonzero mode field lets compare outputs replace port output values.
// - Pin direction stays under the direction bits; software sets them.
// - Complementary pin override uses only whether any mode bit is set; true pin needs PWM with mode 01.
// - Compare output state can be prepared while the pin driver is off.
// - Mode field write acts at the first compare match after it.
// - Force strobe applies the compare action at once in non-PWM modes.
// - Counting uses only PWM enables and waveform mode bits.
// - Normal mode counts up from zero to top, then restarts.
// - Outside PFC mode, counter clears on the cycle after it equals top.
// - Normal mode, mode 1 toggles the waveform output at each match.
// - Normal mode match clears (non-inverting) or sets (inverting) output.
// - Overflow flag sets as counter becomes zero; hardware only sets.
// - Software may write the counter value at any time.
// - Toggle frequency is clock over 2*(1+top); max clock over 2.
// - Normal mode: true pin disconnected, complementary pin shows output.
// - Mode zero drives the pin from the port output register.
// - Forced compare changes only the waveform output.
package ccout_pkg;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_MODE = 8'h04;
    localparam logic [7:0] OFS_FORCE = 8'h08;
    localparam logic [7:0] OFS_COUNT = 8'h0C;
    localparam logic [7:0] OFS_TOP = 8'h10;
    localparam logic [7:0] OFS_CMP0 = 8'h14;
    localparam logic [7:0] OFS_DEAD = 8'h20;
    localparam logic [7:0] OFS_STATUS = 8'h24;
    localparam logic [7:0] OFS_PORT = 8'h28;
    localparam logic [7:0] OFS_DIR = 8'h2C;
    localparam int CMP_STRIDE = 4;
    // Control field positions
    localparam int CTRL_PWMA = 0;
    localparam int CTRL_PWMB = 1;
    localparam int CTRL_WGM_LO = 2;
    // Waveform mode encodings
    localparam logic [1:0] WGM_FAST = 2'h0;
    localparam logic [1:0] WGM_PFC = 2'h1;
    // Compare output mode encodings
    localparam logic [1:0] COM_OFF = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_CLEAR = 2'h2;
    localparam logic [1:0] COM_SET = 2'h3;
    // Reset values
    localparam logic [9:0] RST_TOP = 10'h3FF;
    localparam logic [3:0] RST_CTRL = 4'h0;
    localparam logic [7:0] RST_DEAD = 8'h00;
endpackage

// >>> ccout_timer.sv
// Purpose: Timer counter with compare output stages and dead-time pairs.
// Assumes: Single clock core_clk; APB slave answers with zero wait states.
// Notes: Pin p[2i] is the true pin, p[2i+1] the complementary pin.
//
// Added by the designer: the APB register port and the register offsets.
module ccout_timer #(
    parameter int CW = 10,
    parameter int NCH = 3
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [2*NCH-1:0] pinOut,
    output logic [2*NCH-1:0] pinOe
);
    typedef enum logic [1:0] {
        CCOUT_NORMAL = 2'b00,
        CCOUT_FAST = 2'b01,
        CCOUT_PFC = 2'b10
    } ccout_mode_t;

    logic [3:0] ctrl_q;
    logic [2*NCH-1:0] comMode_q;
    logic [CW-1:0] count_q;
    logic [CW-1:0] top_q;
    logic [CW-1:0] cmp_q [NCH];
    logic [7:0] dead_q;
    logic ovf_q;
    logic [NCH-1:0] cmf_q;
    logic [2*NCH-1:0] port_q;
    logic [2*NCH-1:0] dir_q;
    logic down_q;
    logic block_q;
    logic [NCH-1:0] match_q;
    logic [NCH-1:0] wave_q;
    logic [NCH-1:0] waveDly_q;
    logic [NCH-1:0] ocTrue_q;
    logic [NCH-1:0] ocComp_q;
    logic [3:0] dtCnt_q [NCH];
    logic [31:0] rdata_q;
    logic err_q;

    ccout_mode_t mode;
    logic wrEn;
    logic setupRd;
    logic [NCH-1:0] matchNow;
    logic [NCH-1:0] forceHit;
    logic atTop;
    logic atBottom;
    logic [31:0] rdMux;
    logic rdErr;

    // Decodes channel index for compare value registers
    function automatic logic cmpSel(input logic [7:0] a, input int i);
        cmpSel = (a == 8'(ccout_pkg::OFS_CMP0 + ccout_pkg::CMP_STRIDE * i));
    endfunction

    // Next waveform level for one channel
    function automatic logic waveNext(
        input ccout_mode_t m,
        input logic [1:0] com,
        input logic w,
        input logic hit,
        input logic bot,
        input logic dn
    );
        logic r;
        r = w;
        if (com != ccout_pkg::COM_OFF)
        begin
            case (m)
                CCOUT_NORMAL:
                begin
                    if (hit)
                    begin
                        case (com)
                            ccout_pkg::COM_TOGGLE: r = ~w;
                            ccout_pkg::COM_CLEAR: r = 1'b0;
                            default: r = 1'b1;
                        endcase
                    end
                end
                CCOUT_FAST:
                begin
                    if (hit)
                        r = (com == ccout_pkg::COM_SET);
                    else if (bot)
                        r = (com != ccout_pkg::COM_SET);
                end
                CCOUT_PFC:
                begin
                    if (hit)
                        r = dn ^ (com == ccout_pkg::COM_SET);
                end
                default: r = w;
            endcase
        end
        waveNext = r;
    endfunction

    // Counting sequence picked only from the enables and mode bits
    always_comb
    begin
        if (!ctrl_q[ccout_pkg::CTRL_PWMA] && !ctrl_q[ccout_pkg::CTRL_PWMB])
            mode = CCOUT_NORMAL;
        else if (ctrl_q[ccout_pkg::CTRL_WGM_LO+:2] == ccout_pkg::WGM_PFC)
            mode = CCOUT_PFC;
        else
            mode = CCOUT_FAST;
    end

    assign pready = 1'b1;
    assign wrEn = psel && penable && pwrite;
    assign setupRd = psel && !penable;
    assign atTop = (count_q == top_q);
    assign atBottom = (count_q == '0);

    always_comb
    begin
        for (int i = 0; i < NCH; i++)
        begin
            // A counter write blocks matches in the following cycle
            matchNow[i] = (count_q == cmp_q[i]) && !block_q;
            forceHit[i] = wrEn && (paddr == ccout_pkg::OFS_FORCE) &&
                pwdata[i] && (mode == CCOUT_NORMAL);
        end
    end

    // Control registers
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl_q <= ccout_pkg::RST_CTRL;
            comMode_q <= '0;
            top_q <= ccout_pkg::RST_TOP;
            dead_q <= ccout_pkg::RST_DEAD;
            port_q <= '0;
            dir_q <= '0;
            for (int i = 0; i < NCH; i++)
                cmp_q[i] <= '0;
        end
        else if (wrEn)
        begin
            case (paddr)
                ccout_pkg::OFS_CTRL: ctrl_q <= pwdata[3:0];
                // Read live at each match, so a change acts from the next one
                ccout_pkg::OFS_MODE: comMode_q <= pwdata[2*NCH-1:0];
                ccout_pkg::OFS_TOP: top_q <= pwdata[CW-1:0];
                ccout_pkg::OFS_DEAD: dead_q <= pwdata[7:0];
                ccout_pkg::OFS_PORT: port_q <= pwdata[2*NCH-1:0];
                ccout_pkg::OFS_DIR: dir_q <= pwdata[2*NCH-1:0];
                default:
                begin
                    for (int i = 0; i < NCH; i++)
                        if (cmpSel(paddr, i))
                            cmp_q[i] <= pwdata[CW-1:0];
                end
            endcase
        end
    end

    // Counter; a bus write wins over counting
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            count_q <= '0;
            down_q <= 1'b0;
            block_q <= 1'b0;
        end
        else
        begin
            block_q <= wrEn && (paddr == ccout_pkg::OFS_COUNT);
            if (wrEn && (paddr == ccout_pkg::OFS_COUNT))
                count_q <= pwdata[CW-1:0];
            else if (mode == CCOUT_PFC)
            begin
                if (!down_q && atTop)
                begin
                    down_q <= 1'b1;
                    count_q <= count_q - CW'(1);
                end
                else if (down_q && atBottom)
                begin
                    down_q <= 1'b0;
                    count_q <= count_q + CW'(1);
                end
                else if (down_q)
                    count_q <= count_q - CW'(1);
                else
                    count_q <= count_q + CW'(1);
            end
            else
            begin
                down_q <= 1'b0;
                // Period top+1 gives toggle rate clk/(2*(1+top))
                if (atTop)
                    count_q <= '0;
                else
                    count_q <= count_q + CW'(1);
            end
        end
    end

    // Flags; set beats a software clear in the same cycle
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ovf_q <= 1'b0;
            cmf_q <= '0;
            match_q <= '0;
        end
        else
        begin
            match_q <= matchNow;
            if (wrEn && (paddr == ccout_pkg::OFS_STATUS))
            begin
                ovf_q <= ovf_q & ~pwdata[0];
                cmf_q <= cmf_q & ~pwdata[NCH:1];
            end
            if (mode == CCOUT_PFC)
            begin
                if (down_q && count_q == CW'(1))
                    ovf_q <= 1'b1;
            end
            else if (atTop && !(wrEn && paddr == ccout_pkg::OFS_COUNT))
                ovf_q <= 1'b1;
            // Force never sets these flags
            for (int i = 0; i < NCH; i++)
                if (match_q[i])
                    cmf_q[i] <= 1'b1;
        end
    end

    // Waveform output per channel
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            wave_q <= '0;
        else
        begin
            for (int i = 0; i < NCH; i++)
            begin
                // Zero mode keeps the level force leaves counter alone
                wave_q[i] <= waveNext(mode, comMode_q[2*i+:2], wave_q[i],
                    matchNow[i] || forceHit[i],
                    atTop && mode == CCOUT_FAST, down_q);
            end
        end
    end

    // Dead-time stage; in Normal mode it is a one-cycle synchronizer
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            waveDly_q <= '0;
            ocTrue_q <= '0;
            ocComp_q <= '0;
            for (int i = 0; i < NCH; i++)
                dtCnt_q[i] <= '0;
        end
        else
        begin
            for (int i = 0; i < NCH; i++)
            begin
                waveDly_q[i] <= wave_q[i];
                if (mode != CCOUT_NORMAL &&
                    comMode_q[2*i+:2] == ccout_pkg::COM_TOGGLE)
                begin
                    // Both off while the dead time runs
                    if (wave_q[i] != waveDly_q[i])
                    begin
                        dtCnt_q[i] <= wave_q[i] ? dead_q[7:4] : dead_q[3:0];
                        ocTrue_q[i] <= 1'b0;
                        ocComp_q[i] <= 1'b0;
                    end
                    else if (dtCnt_q[i] != 4'h0)
                        dtCnt_q[i] <= dtCnt_q[i] - 4'h1;
                    else
                    begin
                        ocTrue_q[i] <= waveDly_q[i];
                        ocComp_q[i] <= ~waveDly_q[i];
                    end
                end
                else
                begin
                    // Same path as Normal mode
                    dtCnt_q[i] <= 4'h0;
                    ocTrue_q[i] <= wave_q[i];
                    ocComp_q[i] <= wave_q[i];
                end
            end
        end
    end

    // Pin mux. Output state is kept whatever the direction bit, so it
    // can be prepared by a force before the driver turns on
    always_comb
    begin
        for (int i = 0; i < NCH; i++)
        begin
            pinOe[2*i] = dir_q[2*i];
            pinOe[2*i+1] = dir_q[2*i+1];
            pinOut[2*i] = port_q[2*i];
            pinOut[2*i+1] = port_q[2*i+1];
            // Any set bit overrides, whatever the mode
            if (|comMode_q[2*i+:2])
            begin
                pinOut[2*i+1] = ocComp_q[i];
                // True pin only carries the pair in complementary PWM
                if (mode != CCOUT_NORMAL &&
                    comMode_q[2*i+:2] == ccout_pkg::COM_TOGGLE)
                    pinOut[2*i] = ocTrue_q[i];
            end
        end
    end

    // Read mux
    always_comb
    begin
        rdMux = 32'h0;
        rdErr = 1'b0;
        case (paddr)
            ccout_pkg::OFS_CTRL: rdMux[3:0] = ctrl_q;
            ccout_pkg::OFS_MODE: rdMux[2*NCH-1:0] = comMode_q;
            ccout_pkg::OFS_FORCE: rdMux = 32'h0;
            ccout_pkg::OFS_COUNT: rdMux[CW-1:0] = count_q;
            ccout_pkg::OFS_TOP: rdMux[CW-1:0] = top_q;
            ccout_pkg::OFS_DEAD: rdMux[7:0] = dead_q;
            ccout_pkg::OFS_STATUS: rdMux[NCH:0] = {cmf_q, ovf_q};
            ccout_pkg::OFS_PORT: rdMux[2*NCH-1:0] = port_q;
            ccout_pkg::OFS_DIR: rdMux[2*NCH-1:0] = dir_q;
            default:
            begin
                rdErr = 1'b1;
                for (int i = 0; i < NCH; i++)
                begin
                    if (cmpSel(paddr, i))
                    begin
                        rdMux[CW-1:0] = cmp_q[i];
                        rdErr = 1'b0;
                    end
                end
            end
        endcase
    end

    // Read data and error are captured in the setup cycle
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rdata_q <= 32'h0;
            err_q <= 1'b0;
        end
        else if (setupRd)
        begin
            rdata_q <= rdMux;
            err_q <= rdErr;
        end
    end

    assign prdata = rdata_q;
    assign pslverr = err_q && psel && penable;
endmodule

// >>> ccout_timer_properties.sv
// Purpose: Port-level checker for the compare output timer.
// Assumes: Shadow registers follow APB writes at the access edge.
// Notes: Compare pins with live waveform values are masked out.
module ccout_timer_properties #(
    parameter int CW = 10,
    parameter int NCH = 3
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [2*NCH-1:0] pinOut,
    input wire logic [2*NCH-1:0] pinOe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] mode_q;
    logic [31:0] port_q;
    logic [31:0] ctrl_q;
    logic [2*NCH-1:0] mask;
    logic [2*NCH-1:0] dirVal;
    logic wrEn;
    logic dirWr;
    logic forceSet;
    assign wrEn = psel && penable && pwrite;
    assign dirWr = wrEn && paddr == ccout_pkg::OFS_DIR;
    assign dirVal = pwdata[2*NCH-1:0];
    assign forceSet = wrEn && paddr == ccout_pkg::OFS_FORCE && pwdata[0]
        && ctrl_q[1:0] == 2'h0 && mode_q[1:0] == ccout_pkg::COM_SET;
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            mode_q <= '0;
            port_q <= '0;
            ctrl_q <= '0;
        end
        else if (wrEn)
        begin
            if (paddr == ccout_pkg::OFS_MODE)
                mode_q <= pwdata;
            if (paddr == ccout_pkg::OFS_PORT)
                port_q <= pwdata;
            if (paddr == ccout_pkg::OFS_CTRL)
                ctrl_q <= pwdata;
        end
    end
    // Only the complementary PWM pair takes the true pin away from the port
    always_comb
    begin
        for (int i = 0; i < NCH; i++)
        begin
            mask[2*i] = !(ctrl_q[1:0] != 2'h0 && mode_q[2*i+:2] == 2'h1);
            mask[2*i+1] = mode_q[2*i+:2] == 2'h0;
        end
    end
    a_ready_high: assert property (@(posedge core_clk) disable iff (!reset_n)
        pready) else $error("pready low");
    a_error_in_access: assert property (@(posedge core_clk)
        disable iff (!reset_n) pslverr |-> psel && penable)
        else $error("pslverr outside access");
    a_unmapped_error: assert property (@(posedge core_clk)
        disable iff (!reset_n) psel && penable && paddr == 8'h30 |-> pslverr)
        else $error("unmapped access not refused");
    a_reset_pins_low: assert property (@(posedge core_clk)
        disable iff (!reset_n) $rose(reset_n) |-> pinOut == '0 && pinOe == '0)
        else $error("pins not zero after reset");
    a_dir_to_oe: assert property (@(posedge core_clk)
        disable iff (!reset_n) dirWr |=> pinOe == $past(dirVal))
        else $error("pinOe differs from direction write");
    a_oe_only_dir: assert property (@(posedge core_clk)
        disable iff (!reset_n) !$stable(pinOe) |-> $past(dirWr))
        else $error("pinOe changed without direction write");
    a_port_override: assert property (@(posedge core_clk)
        disable iff (!reset_n) (pinOut & mask) == (port_q[2*NCH-1:0] & mask))
        else $error("port value not on pin");
    a_force_sync: assert property (@(posedge core_clk)
        disable iff (!reset_n) forceSet && !pinOut[1]
        |=> !pinOut[1] ##1 pinOut[1])
        else $error("forced set not one cycle behind");
    // The strobe register holds nothing, so a read must give zero
    a_force_reads_zero: assert property (@(posedge core_clk)
        disable iff (!reset_n) psel && penable && !pwrite &&
        paddr == ccout_pkg::OFS_FORCE |-> prdata == 32'h0)
        else $error("force register read not zero");
endmodule

bind ccout_timer ccout_timer_properties #(.CW(CW), .NCH(NCH))
    i_ccout_timer_properties (.core_clk, .reset_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .pinOut, .pinOe);

// >>> ccout_load.sv
// Purpose: Load seen by the compare pins.
// Assumes: No pull resistor on the pins.
// Notes: An undriven pin wanders so stale values never pass.
module ccout_load #(
    parameter int NCH = 3
) (
    input wire logic core_clk,
    input wire logic [2*NCH-1:0] pinOut,
    input wire logic [2*NCH-1:0] pinOe,
    output logic [2*NCH-1:0] pinLevel
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2*NCH-1:0] last_q = '0;
    assign pinLevel = (pinOe & pinOut) | (~pinOe & ~last_q);
    always_ff @(posedge core_clk)
    begin
        last_q <= pinLevel;
    end
endmodule

// >>> compare_output_normal_mode_test.sv
// Purpose: Self-checking bench for the compare output timer.
// Assumes: Zero wait APB; pin table and prepared pin seen through the load model, other checks read pinOut.
// Notes: Small top values keep every period short.
module compare_output_normal_mode_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [5:0] pinOut;
    logic [5:0] pinOe;
    logic [5:0] pinLevel;
    int num_errors = 0;
    int checks = 0;

    ccout_timer i_ccout_timer (.core_clk, .reset_n, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .pinOut, .pinOe);
    ccout_load i_ccout_load (.core_clk, .pinOut, .pinOe, .pinLevel);

    initial
    begin
        forever #12.5 core_clk = ~core_clk;
    end

    task automatic results;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic guard(input int n);
        if (n >= 3000)
        begin
            num_errors++;
            $display("timeout");
            results();
        end
    endtask

    task automatic check_val(input string nm, input logic [31:0] ex,
        input logic [31:0] got);
        checks++;
        if (got !== ex)
        begin
            num_errors++;
            $display("wrong value %s exp %h got %h", nm, ex, got);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic e);
        int n;
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 3000);
        guard(n);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask

    function automatic logic [5:0] pin_mask(input logic [5:0] m,
        input logic pwm);
        logic [5:0] r;
        for (int i = 0; i < 3; i++)
        begin
            r[2*i] = !(pwm && m[2*i+:2] == 2'h1);
            r[2*i+1] = m[2*i+:2] == 2'h0;
        end
        return r;
    endfunction

    // One pin of the pair is high for its wave phase less dead count plus one
    function automatic int pair_high(input int w, input int d);
        return 12 * (w - d - 1);
    endfunction

    // Time between two toggles of the complementary pin of channel 0
    task automatic half_period(input int t);
        int n;
        logic v;
        @(negedge core_clk);
        for (int k = 0; k < 2; k++)
        begin
            v = pinOut[1];
            n = 0;
            do
            begin
                @(negedge core_clk);
                n++;
            end
            while (pinOut[1] === v && n < 3000);
            guard(n);
        end
        check_val("half period", t + 1, n);
    endtask

    initial
    begin
        logic [31:0] q;
        logic e;
        logic [5:0] pt;
        logic [5:0] dr;
        logic [5:0] md;
        logic pw;
        int t;
        int ov;
        int hiT;
        int hiC;
        void'($urandom(32'hB663));
        repeat (6) @(posedge core_clk);
        reset_n <= 1'b1;
        apb(1'b0, ccout_pkg::OFS_TOP, 32'h0, q, e);
        check_val("top reset", 32'h3FF, q);
        check_val("pins reset", 32'h0, {pinOe, pinOut});
        apb(1'b0, 8'h30, 32'h0, q, e);
        check_val("unmapped data", 32'h0, q);
        check_val("unmapped err", 32'h1, e);
        $display("test reset done");
        for (int k = 0; k < 10; k++)
        begin
            pt = $urandom;
            dr = $urandom;
            md = $urandom;
            pw = $urandom;
            wr(ccout_pkg::OFS_CTRL, {31'h0, pw});
            wr(ccout_pkg::OFS_PORT, pt);
            wr(ccout_pkg::OFS_DIR, dr);
            wr(ccout_pkg::OFS_MODE, md);
            @(negedge core_clk);
            check_val("pin", pt & dr & pin_mask(md, pw),
                pinLevel & dr & pin_mask(md, pw));
            check_val("pin enable", dr, pinOe);
        end
        $display("test pin table done");
        // Compare value beyond top, so only the strobe moves the output
        wr(ccout_pkg::OFS_CTRL, 32'h0);
        wr(ccout_pkg::OFS_TOP, 32'h10);
        wr(ccout_pkg::OFS_CMP0, 32'h200);
        wr(ccout_pkg::OFS_STATUS, 32'hF);
        // Driver off while the level is prepared
        wr(ccout_pkg::OFS_DIR, 32'h0);
        wr(ccout_pkg::OFS_MODE, ccout_pkg::COM_SET);
        wr(ccout_pkg::OFS_FORCE, 32'h1);
        repeat (3) @(negedge core_clk);
        check_val("forced set", 32'h1, pinOut[1]);
        wr(ccout_pkg::OFS_DIR, 32'h2);
        @(negedge core_clk);
        check_val("prepared pin", 32'h1, pinLevel[1]);
        wr(ccout_pkg::OFS_MODE, ccout_pkg::COM_CLEAR);
        wr(ccout_pkg::OFS_FORCE, 32'h1);
        repeat (3) @(negedge core_clk);
        check_val("forced clear", 32'h0, pinOut[1]);
        apb(1'b0, ccout_pkg::OFS_STATUS, 32'h0, q, e);
        check_val("match flags", 32'h0, q[3:1]);
        apb(1'b0, ccout_pkg::OFS_FORCE, 32'h0, q, e);
        check_val("force read", 32'h0, q);
        $display("test force done");
        wr(ccout_pkg::OFS_MODE, ccout_pkg::COM_TOGGLE);
        for (int k = 0; k < 4; k++)
        begin
            t = (k == 0) ? 0 : $urandom_range(20, 1);
            wr(ccout_pkg::OFS_TOP, t);
            wr(ccout_pkg::OFS_CMP0, $urandom_range(t, 0));
            wr(ccout_pkg::OFS_COUNT, 32'h0);
            half_period(t);
            wr(ccout_pkg::OFS_STATUS, 32'h1);
            repeat (t + 3) @(posedge core_clk);
            apb(1'b0, ccout_pkg::OFS_STATUS, 32'h0, q, e);
            check_val("overflow", 32'h1, q[0]);
        end
        $display("test toggle done");
        wr(ccout_pkg::OFS_TOP, 32'h3FF);
        t = $urandom_range(32'h300, 0);
        wr(ccout_pkg::OFS_COUNT, t);
        apb(1'b0, ccout_pkg::OFS_COUNT, 32'h0, q, e);
        check_val("count", t + 1, q);
        $display("test count done");
        wr(ccout_pkg::OFS_CTRL, 32'h1);
        wr(ccout_pkg::OFS_DEAD, 32'h21);
        wr(ccout_pkg::OFS_TOP, 32'h0F);
        wr(ccout_pkg::OFS_CMP0, 32'h06);
        // Restart below top, else the count runs to its wrap first
        wr(ccout_pkg::OFS_COUNT, 32'h0);
        wr(ccout_pkg::OFS_MODE, 32'h1);
        ov = 0;
        hiT = 0;
        hiC = 0;
        repeat (40) @(negedge core_clk);
        // Twelve whole periods of 16 cycles, so the phase does not matter
        repeat (192)
        begin
            @(negedge core_clk);
            ov += pinOut[0] & pinOut[1];
            hiT += pinOut[0];
            hiC += pinOut[1];
        end
        check_val("overlap", 32'h0, ov);
        check_val("true high", pair_high(7, 2), hiT);
        check_val("comp high", pair_high(9, 1), hiC);
        wr(ccout_pkg::OFS_MODE, ccout_pkg::COM_CLEAR);
        repeat (40) @(posedge core_clk);
        $display("test pair done");
        // A second reset mid-run must clear the pins again
        reset_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        @(negedge core_clk);
        check_val("pins rereset", 32'h0, {pinOe, pinOut});
        $display("test reset again done");
        results();
    end
endmodule
